// ==== verilog/serial_flash_status.v ====
// Status/control register and command framing of a serial flash, seen from the pins.
// Assumes pins asynchronous to clk (sampled twice); rst_b stands for power-up;
// protect_hit comes from array-side range decode on clk.
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_defines.vh"

module serial_flash_status #(
  parameter OP_CYCLES = `OP_CYCLES
) (
  input wire clk,
  input wire rst_b,
  input wire cs_b,
  input wire sclk,
  input wire si,
  input wire wp_b,
  input wire protect_hit,
  output reg so,
  output reg so_oe,
  output reg [15:0] status_word,
  output reg [4:0] protect_range,
  output reg protect_invert,
  output reg quad_io_enable,
  output reg security_area_lock,
  output reg deep_power_down,
  output reg op_start,
  output reg [7:0] op_code,
  output reg [23:0] op_addr
);

  localparam PIN_CS = 0;
  localparam PIN_SCLK = 1;
  localparam PIN_SI = 2;
  localparam PIN_WP = 3;

  // Two-stage pin synchronisers plus one history stage for edges
  reg [3:0] pin_s1_reg;
  reg [3:0] pin_s2_reg;
  reg [1:0] pin_d_reg;
  wire sclk_rise = pin_s2_reg[PIN_SCLK] & ~pin_d_reg[1];
  wire sclk_fall = ~pin_s2_reg[PIN_SCLK] & pin_d_reg[1];
  wire cs_rise = pin_s2_reg[PIN_CS] & ~pin_d_reg[0];
  wire selected = ~pin_s2_reg[PIN_CS];

  reg [15:0] stored_reg;
  reg latch_reg;
  reg busy_reg;
  reg sus_reg;
  reg [15:0] timer_reg;
  reg [7:0] in_shift_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] byte_cnt_reg;
  reg [7:0] cmd_reg;
  reg [7:0] wr_lo_reg;
  reg [7:0] wr_hi_reg;
  reg [23:0] addr_reg;
  reg read_active_reg;
  reg read_upper_reg;
  reg [7:0] out_shift_reg;
  reg [2:0] out_cnt_reg;

  wire busy_shown = busy_reg & ~sus_reg;
  wire [15:0] status_now;
  wire [1:0] lock_mode = {stored_reg[`ST_LOCK_UPPER], stored_reg[`ST_LOCK_LOWER]};
  // With quad mode on the pin is a data line, so it no longer protects
  wire wp_level = stored_reg[`ST_QUAD] | pin_s2_reg[PIN_WP];
  wire [7:0] byte_now = {in_shift_reg[6:0], pin_s2_reg[PIN_SI]};
  wire on_boundary = (bit_cnt_reg == 3'd0);
  wire status_write_ok;
  wire chip_erase_ok;
  wire [15:0] write_data;
  wire [15:0] status_next;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  wire buf_pop;
  wire buf_flush;

  assign status_now = {sus_reg, stored_reg[`ST_INVERT], 3'b000,
                       stored_reg[`ST_SEC_LOCK:`ST_BP_LO], latch_reg, busy_shown};

  // Lock modes 10 and 11 refuse every write; 01 follows the pin
  assign status_write_ok = latch_reg & ((lock_mode == 2'b00) |
                           ((lock_mode == 2'b01) & wp_level));

  assign chip_erase_ok = ((stored_reg[`ST_BP_LO+2:`ST_BP_LO] == 3'b000) &
                          ~stored_reg[`ST_INVERT]) |
                         ((stored_reg[`ST_BP_LO+2:`ST_BP_LO] == 3'b111) &
                          stored_reg[`ST_INVERT]);

  // A one-byte status write leaves the upper byte as it is
  assign write_data = {(byte_cnt_reg >= `BYTES_STATUS_HI) ? wr_hi_reg : stored_reg[15:8],
                       wr_lo_reg};
  assign status_next = ((stored_reg & ~`STATUS_WR_MASK) |
                        (write_data & `STATUS_WR_MASK)) |
                       (stored_reg & (16'h0001 << `ST_SEC_LOCK));

  // Snapshots may be up to two bytes old; the buffer trades freshness for no stall
  assign buf_pop = sclk_fall & selected & read_active_reg & (out_cnt_reg == 3'd0);
  assign buf_flush = ~selected;

  read_byte_buffer #(
    .WIDTH(`RD_BUF_WIDTH),
    .DEPTH(`RD_BUF_DEPTH),
    .PTR_W(1)
  ) u_read_buf (
    .clk(clk),
    .rst_b(rst_b),
    .flush(buf_flush),
    .in_valid(read_active_reg & selected),
    .in_ready(buf_in_ready),
    .in_data(read_upper_reg ? status_now[15:8] : status_now[7:0]),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_reg <= 4'b1011;
      pin_s2_reg <= 4'b1011;
      pin_d_reg <= 2'b11;
    end else begin
      pin_s1_reg <= {wp_b, si, sclk, cs_b};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= {pin_s2_reg[PIN_SCLK], pin_s2_reg[PIN_CS]};
    end
  end

  // Serial framing: bits in on rising clock, bytes counted from select
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_shift_reg <= 8'h00;
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 8'h00;
      cmd_reg <= 8'h00;
      wr_lo_reg <= 8'h00;
      wr_hi_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
      read_active_reg <= 1'b0;
      read_upper_reg <= 1'b0;
    end else if (!selected) begin
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 8'h00;
      read_active_reg <= 1'b0;
    end else if (sclk_rise) begin
      in_shift_reg <= byte_now;
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
      if (bit_cnt_reg == 3'd7) begin
        if (byte_cnt_reg != 8'hff) begin
          byte_cnt_reg <= byte_cnt_reg + 8'h01;
        end
        if (byte_cnt_reg == 8'h00) begin
          cmd_reg <= byte_now;
          if (!deep_power_down && (byte_now == `CMD_READ_STATUS_LO ||
              byte_now == `CMD_READ_STATUS_HI)) begin
            read_active_reg <= 1'b1;
            read_upper_reg <= (byte_now == `CMD_READ_STATUS_HI);
          end
        end
        if (byte_cnt_reg >= 8'h01 && byte_cnt_reg <= 8'h03) begin
          addr_reg <= {addr_reg[15:0], byte_now};
        end
        if (byte_cnt_reg == 8'h01) begin
          wr_lo_reg <= byte_now;
        end
        if (byte_cnt_reg == 8'h02) begin
          wr_hi_reg <= byte_now;
        end
      end
    end
  end

  // Output shifter: new byte on the fall after each byte boundary
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_shift_reg <= 8'h00;
      out_cnt_reg <= 3'd0;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (!selected || !read_active_reg) begin
      out_cnt_reg <= 3'd0;
      so_oe <= 1'b0;
      so <= 1'b0;
    end else if (sclk_fall) begin
      so_oe <= 1'b1;
      if (out_cnt_reg == 3'd0) begin
        out_shift_reg <= buf_out_valid ? buf_out_data : 8'h00;
        so <= buf_out_valid ? buf_out_data[7] : 1'b0;
        out_cnt_reg <= 3'd7;
      end else begin
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        so <= out_shift_reg[6];
        out_cnt_reg <= out_cnt_reg - 3'd1;
      end
    end
  end

  // Command execution on deselect, plus the busy timer
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stored_reg <= `STATUS_RESET;
      latch_reg <= 1'b0;
      busy_reg <= 1'b0;
      sus_reg <= 1'b0;
      timer_reg <= 16'h0000;
      deep_power_down <= 1'b0;
      op_start <= 1'b0;
      op_code <= 8'h00;
      op_addr <= 24'h00_0000;
    end else begin
      op_start <= 1'b0;
      if (busy_reg && !sus_reg) begin
        if (timer_reg <= 16'h0001) begin
          busy_reg <= 1'b0;
          latch_reg <= 1'b0;
        end else begin
          timer_reg <= timer_reg - 16'h0001;
        end
      end
      if (cs_rise && byte_cnt_reg != 8'h00) begin
        if (deep_power_down) begin
          if (cmd_reg == `CMD_RELEASE_DOWN) begin
            deep_power_down <= 1'b0;
          end
        end else if (cmd_reg == `CMD_SUSPEND) begin
          if (busy_reg) begin
            sus_reg <= 1'b1;
          end
        end else if (cmd_reg == `CMD_RESUME) begin
          sus_reg <= 1'b0;
        end else if (on_boundary && !busy_reg) begin
          case (cmd_reg)
            `CMD_WR_LATCH_SET: begin
              if (byte_cnt_reg == `BYTES_OPCODE) begin
                latch_reg <= 1'b1;
              end
            end
            `CMD_WR_LATCH_CLEAR: begin
              if (byte_cnt_reg == `BYTES_OPCODE) begin
                latch_reg <= 1'b0;
              end
            end
            `CMD_STATUS_WRITE: begin
              if (status_write_ok && byte_cnt_reg >= `BYTES_STATUS_LO &&
                  byte_cnt_reg <= `BYTES_STATUS_HI) begin
                stored_reg <= status_next;
                busy_reg <= 1'b1;
                timer_reg <= OP_CYCLES[15:0];
              end
            end
            `CMD_PAGE_PROGRAM: begin
              if (latch_reg && !protect_hit && byte_cnt_reg >= `BYTES_PROGRAM_MIN) begin
                busy_reg <= 1'b1;
                timer_reg <= OP_CYCLES[15:0];
                op_start <= 1'b1;
                op_code <= cmd_reg;
                op_addr <= addr_reg;
              end
            end
            `CMD_SECTOR_ERASE, `CMD_BLOCK_ERASE_32, `CMD_BLOCK_ERASE_64: begin
              if (latch_reg && !protect_hit && byte_cnt_reg == `BYTES_ADDRESSED) begin
                busy_reg <= 1'b1;
                timer_reg <= OP_CYCLES[15:0];
                op_start <= 1'b1;
                op_code <= cmd_reg;
                op_addr <= addr_reg;
              end
            end
            `CMD_CHIP_ERASE_A, `CMD_CHIP_ERASE_B: begin
              if (latch_reg && chip_erase_ok && byte_cnt_reg == `BYTES_OPCODE) begin
                busy_reg <= 1'b1;
                timer_reg <= OP_CYCLES[15:0];
                op_start <= 1'b1;
                op_code <= cmd_reg;
                op_addr <= 24'h00_0000;
              end
            end
            `CMD_DEEP_DOWN: begin
              if (byte_cnt_reg == `BYTES_OPCODE) begin
                deep_power_down <= 1'b1;
              end
            end
            default: begin
              op_start <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Registered views of the register for the array side and observers
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_word <= 16'h0000;
      protect_range <= 5'b00000;
      protect_invert <= 1'b0;
      quad_io_enable <= 1'b0;
      security_area_lock <= 1'b0;
    end else begin
      status_word <= status_now;
      protect_range <= stored_reg[`ST_BP_HI:`ST_BP_LO];
      protect_invert <= stored_reg[`ST_INVERT];
      quad_io_enable <= stored_reg[`ST_QUAD];
      security_area_lock <= stored_reg[`ST_SEC_LOCK];
    end
  end

endmodule

`default_nettype wire

// ==== verilog/flash_status_defines.vh ====
// Constants for the serial flash status/control register and command framing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef FLASH_STATUS_DEFINES_VH
`define FLASH_STATUS_DEFINES_VH

// Status word field positions
`define ST_BUSY 0
`define ST_LATCH 1
`define ST_BP_LO 2
`define ST_BP_HI 6
`define ST_LOCK_LOWER 7
`define ST_LOCK_UPPER 8
`define ST_QUAD 9
`define ST_SEC_LOCK 10
`define ST_INVERT 14
`define ST_SUS 15

// Reset value of the stored bits and mask of the bits a status write may change
`define STATUS_RESET 16'h0000
`define STATUS_WR_MASK 16'h47fc

// Command codes
`define CMD_WR_LATCH_SET 8'h06
`define CMD_WR_LATCH_CLEAR 8'h04
`define CMD_READ_STATUS_LO 8'h05
`define CMD_READ_STATUS_HI 8'h35
`define CMD_STATUS_WRITE 8'h01
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_SECTOR_ERASE 8'h20
`define CMD_BLOCK_ERASE_32 8'h52
`define CMD_BLOCK_ERASE_64 8'hd8
`define CMD_CHIP_ERASE_A 8'hc7
`define CMD_CHIP_ERASE_B 8'h60
`define CMD_SUSPEND 8'h75
`define CMD_RESUME 8'h7a
`define CMD_DEEP_DOWN 8'hb9
`define CMD_RELEASE_DOWN 8'hab

// Frame lengths in bytes
`define BYTES_OPCODE 8'h01
`define BYTES_ADDRESSED 8'h04
`define BYTES_PROGRAM_MIN 8'h05
`define BYTES_STATUS_LO 8'h02
`define BYTES_STATUS_HI 8'h03

// Timing: busy time of a program, erase or status write
`define CLK_MHZ 50
`define OP_TIME_US 100
`define OP_CYCLES (`OP_TIME_US * `CLK_MHZ)

// Read buffer shape
`define RD_BUF_WIDTH 8
`define RD_BUF_DEPTH 2

`endif

// ==== verilog/read_byte_buffer.v ====
// Small FIFO holding status bytes between the snapshot logic and the output shifter.
// Assumes a single clock; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none

module read_byte_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter PTR_W = 1
) (
  input wire clk,
  input wire rst_b,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[PTR_W:0]);
  assign out_valid = (count_reg != {(PTR_W+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg <= {(PTR_W+1){1'b0}};
    end else if (flush) begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} :
                      wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} :
                      rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== bench/flash_status_asserts.sv ====
// Concurrent checks on the pins and status outputs of the flash status block.
// Assumes binding into serial_flash_status; all outputs registered on clk.
`timescale 1ns/1ps
`default_nettype none
module flash_status_asserts #(
  parameter OP_CYCLES = 5000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic si,
  input wire logic wp_b,
  input wire logic protect_hit,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [15:0] status_word,
  input wire logic [4:0] protect_range,
  input wire logic protect_invert,
  input wire logic quad_io_enable,
  input wire logic security_area_lock,
  input wire logic deep_power_down,
  input wire logic op_start,
  input wire logic [7:0] op_code,
  input wire logic [23:0] op_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  rsvd_zero_a: assert property (status_word[13:11] == 3'h0)
    else $error("reserved status bits set");
  op_busy_a: assert property (op_start |-> ##[1:3] status_word[1:0] == 2'h3)
    else $error("busy not shown after op start");
  op_wel_a: assert property (op_start |-> $past(status_word[1]))
    else $error("op started with latch clear");
  op_desel_a: assert property (op_start |-> cs_b && $past(cs_b, 2))
    else $error("op started before deselect");
  chip_erase_a: assert property (op_start && op_code inside {8'hc7, 8'h60} |->
    status_word[4:2] == {3{status_word[14]}})
    else $error("chip erase ran in protected setting");
  // Lock mode 10 and 11 freeze every stored bit until power-up
  lock_hold_a: assert property ($changed(status_word[14:2]) |-> !$past(status_word[8]))
    else $error("stored bits changed while locked");
  oe_release_a: assert property ($rose(cs_b) |-> ##[1:5] !so_oe)
    else $error("output kept driving after deselect");
  wel_drop_a: assert property ($fell(status_word[0]) && !status_word[15] |->
    !status_word[1])
    else $error("latch kept after op end");
  sus_busy_a: assert property ($rose(status_word[15]) |-> $past(status_word[0]))
    else $error("suspend flag set while idle");
endmodule
bind serial_flash_status flash_status_asserts #(.OP_CYCLES(OP_CYCLES)) chk_u (
  .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .si(si), .wp_b(wp_b),
  .protect_hit(protect_hit), .so(so), .so_oe(so_oe), .status_word(status_word),
  .protect_range(protect_range), .protect_invert(protect_invert),
  .quad_io_enable(quad_io_enable), .security_area_lock(security_area_lock),
  .deep_power_down(deep_power_down), .op_start(op_start), .op_code(op_code),
  .op_addr(op_addr));
`default_nettype wire

// ==== bench/flash_host.sv ====
// Host serial controller model: frames commands on the select, clock and data pins.
// Assumes a 50 MHz clk; half an sclk period is four clk cycles (160 ns period).
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  input wire logic clk,
  output logic cs_b,
  output logic sclk,
  output logic si,
  input wire logic so
);
  initial begin
    cs_b = 1'b1;
    sclk = 1'b1;
    si = 1'b0;
  end
  // Clock idles high and stands still between frames
  task automatic frame(input logic [39:0] tx, input int nb, input int nr,
                       output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk) cs_b <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = nb - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      si <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    for (int i = 0; i < nr; i++) begin
      sclk <= 1'b0;
      si <= ~si;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      rx = {rx[14:0], so};
    end
    cs_b <= 1'b1;
    si <= ~si;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_serial_flash_status.sv ====
// Bench for the flash status block: host model frames commands, integer model
// predicts status and accepted ops. Assumes busy time shortened to OPC cycles.
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_defines.vh"
module tb_serial_flash_status;
  localparam int OPC = 200;
  logic clk, rst_b, wp_b, protect_hit, m_latch, m_busy, m_dpd;
  wire logic cs_b, sclk, si, so, so_oe, inv, quad, sec_lock, dpd, op_start;
  wire logic [15:0] status_word;
  wire logic [4:0] prange;
  wire logic [7:0] op_code;
  wire logic [23:0] op_addr;
  logic [15:0] m_sr, rx;
  logic [7:0] lfsr;
  logic [23:0] addr;
  int error_cnt, tests_run, ops, m_ops;
  serial_flash_status #(.OP_CYCLES(OPC)) dut_u (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
    .sclk(sclk), .si(si), .wp_b(wp_b), .protect_hit(protect_hit), .so(so), .so_oe(so_oe),
    .status_word(status_word), .protect_range(prange), .protect_invert(inv),
    .quad_io_enable(quad), .security_area_lock(sec_lock), .deep_power_down(dpd),
    .op_start(op_start), .op_code(op_code), .op_addr(op_addr));
  flash_host host_u (.clk(clk), .cs_b(cs_b), .sclk(sclk), .si(si), .so(so));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (op_start === 1'b1) ops <= ops + 1;
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Sends one frame, then updates the model as the device should
  task automatic send(input logic [39:0] tx, input int nb, input bit wt = 1);
    logic [7:0] op;
    logic [15:0] d;
    op = 8'(tx >> (nb - 8));
    d = {tx[7:0], tx[15:8]};
    host_u.frame(tx, nb, 0, rx);
    if (nb % 8 == 0 && (!m_dpd || op == 8'hab)) begin
      case (op)
        8'h06: m_latch = 1'b1;
        8'h04: m_latch = 1'b0;
        8'hb9: m_dpd = 1'b1;
        8'hab: m_dpd = 1'b0;
        8'h75: m_sr[15] = m_busy;
        8'h7a: m_sr[15] = 1'b0;
        8'h01: m_busy = m_latch && (m_sr[8:7] == 2'h0 ||
                        m_sr[8:7] == 2'h1 && (wp_b || m_sr[9]));
        8'h02, 8'h20, 8'h52, 8'hd8: m_busy = m_latch && !protect_hit;
        8'hc7, 8'h60: m_busy = m_latch && m_sr[4:2] == {3{m_sr[14]}};
        default: ;
      endcase
      if (m_busy && op == 8'h01)
        m_sr = (m_sr & ~`STATUS_WR_MASK) | (d & `STATUS_WR_MASK) | (m_sr & 16'h0400);
      if (m_busy && op inside {8'h02, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60}) m_ops++;
    end
    repeat (8) @(posedge clk);
    check(status_word[0], m_busy && !m_sr[15]);
    check(ops, m_ops);
    if (wt) begin
      for (int i = 0; i < OPC + 20 && status_word[0] !== 1'b0; i++) @(posedge clk);
      if (m_busy) m_latch = 1'b0;
      m_busy = 1'b0;
    end
  endtask
  // Low byte is read twice to push the read buffer through a refill
  task automatic rd_chk;
    logic [15:0] lo, hi, e;
    e = m_sr | {m_latch, 1'b0};
    host_u.frame(40'h05, 8, 16, lo);
    host_u.frame(40'h35, 8, 8, hi);
    check({hi[7:0], lo}, {e[15:8], e[7:0], e[7:0]});
    check(status_word, e);
  endtask
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    protect_hit = 1'b0;
    {m_latch, m_busy, m_dpd, m_sr, lfsr} = {3'h0, 16'h0000, 8'h51};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk();
    send(40'h03, 7);
    rd_chk();
    send(40'h01_9c78, 24);
    rd_chk();
    send(40'h06, 8);
    send(40'h01_9c78, 24);
    rd_chk();
    check({inv, prange}, {m_sr[14], m_sr[6:2]});
    send(40'h06, 8);
    send(40'hc7, 8);
    rd_chk();
    wp_b <= 1'b0;
    send(40'h06, 8);
    send(40'h01_0004, 24);
    rd_chk();
    wp_b <= 1'b1;
    send(40'h01_0004, 24);
    rd_chk();
    check(sec_lock, 1'b1);
    wp_b <= 1'b0;
    send(40'h06, 8);
    send(40'h01_0400, 24);
    rd_chk();
    wp_b <= 1'b1;
    send(40'h06, 8);
    send(40'h60, 8);
    rd_chk();
    send(40'h04, 8);
    rd_chk();
    send(40'h06, 8);
    for (int k = 0; k < 3; k++) begin
      addr = {3{lfsr}};
      lfsr = nxt(lfsr);
      protect_hit <= (k == 1);
      send({8'h02, addr, lfsr} >> (k == 0 ? 3 : 0), k == 0 ? 37 : 40);
      rd_chk();
    end
    check({op_code, op_addr}, {8'h02, addr});
    send(40'h06, 8);
    send({8'h20, addr}, 32, 0);
    send(40'h75, 8, 0);
    rd_chk();
    send(40'h7a, 8);
    rd_chk();
    send(40'h5c, 7);
    check(dpd, m_dpd);
    send(40'hb9, 8);
    send(40'h06, 8);
    check(dpd, m_dpd);
    send(40'hab, 8);
    rd_chk();
    // Block erases: protected one refused with latch kept, then one accepted
    send(40'h06, 8);
    protect_hit <= 1'b1;
    send({8'h52, addr}, 32);
    protect_hit <= 1'b0;
    send({8'hd8, lfsr, addr[15:0]}, 32);
    check({op_code, op_addr}, {8'hd8, lfsr, addr[15:0]});
    rd_chk();
    for (int s = 1; s < 4; s++) begin
      send(40'h06, 8);
      send({8'h01, s[0], 7'h00, 6'h00, 1'b1, s[1]}, 24);
      wp_b <= 1'b0;
      send(40'h06, 8);
      send({8'h01, s[0], 7'h04, 6'h00, 1'b1, s[1]}, 24);
      rd_chk();
      check(quad, 1'b1);
      rst_b <= 1'b0;
      {m_latch, m_sr} = 17'h0_0000;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      wp_b <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk();
    end
    stop_test();
  end
  // Run needs roughly 16k clk; 75k clk is ample margin
  initial begin
    #1_500_000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
